//--- ffl_fifo.sv
// Soft FIFO with documented flag update latencies and AXI4-Lite control
`timescale 1ns/1ps
module ffl_fifo
  import ffl_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned N = 2,
  parameter int unsigned PW = $clog2(DEPTH) + 1,
  parameter logic [PW-1:0] THR_HI_RST = PW'(DEPTH - 2),
  parameter logic [PW-1:0] THR_LO_RST = PW'(2)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [FFL_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [FFL_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic write_side_clock,
  input wire logic push_req,
  input wire logic [WIDTH-1:0] push_data,
  output logic full,
  output logic near_capacity_flag,
  output logic threshold_high_flag,
  output logic write_accept_pulse,
  output logic write_rejected_flag,
  output logic [PW-1:0] write_side_occupancy,
  input wire logic read_side_clock,
  input wire logic pop_req,
  output logic [WIDTH-1:0] pop_data,
  output logic empty,
  output logic near_drained_flag,
  output logic threshold_low_flag,
  output logic read_output_qualifier,
  output logic read_rejected_flag,
  output logic [PW-1:0] read_side_occupancy,
  output logic [PW-1:0] shared_occupancy_count,
  output logic irq
);
  localparam int unsigned AW = PW - 1;
  localparam logic [PW-1:0] FULLV = PW'(DEPTH);
  localparam logic [PW-1:0] NEARV = PW'(DEPTH - 1);
  localparam logic [PW-1:0] ONEV = PW'(1);

  typedef struct packed {
    logic [FFL_CLK_PIPE-1:0] wc;
    logic [FFL_CLK_PIPE-1:0] rc;
    logic [FFL_PIN_SYNC-1:0] we;
    logic [FFL_PIN_SYNC-1:0] re;
    logic [FFL_PIN_SYNC-1:0][WIDTH-1:0] wd;
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [N+3:0][PW-1:0] wl;
    logic [N+2:0][PW-1:0] rl;
    logic [WIDTH-1:0] dout;
    logic full;
    logic afull;
    logic pfull;
    logic ack;
    logic ovf;
    logic empty;
    logic aempty;
    logic pempty;
    logic valid;
    logic udf;
    logic [PW-1:0] wcnt;
    logic [PW-1:0] rcnt;
    logic [PW-1:0] scnt;
    logic [PW-1:0] thr_hi;
    logic [PW-1:0] thr_lo;
    ffl_ctrl_s ctrl;
    ffl_irq_s ist;
    ffl_irq_s imsk;
    logic irq;
    logic awr;
    logic wrdy;
    logic arr;
    logic aw_got;
    logic w_got;
    logic [FFL_AW-1:0] awa;
    logic [31:0] wdat;
    logic wstb;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } st_s;

  st_s s;
  st_s n;
  st_s rstv;
  logic wt;
  logic rt;
  logic indep;
  logic look;

  assign indep = s.ctrl.indep;
  assign look = s.ctrl.lookahead_read_mode;
  // Edge found one flop after the synchroniser; data goes through the same two flops
  assign wt = s.wc[1] & ~s.wc[2];
  assign rt = indep ? (s.rc[1] & ~s.rc[2]) : wt;

  always_comb begin
    logic wacc;
    logic racc;
    logic [PW-1:0] wv;
    logic [PW-1:0] ev;
    logic [PW-1:0] av;
    ffl_irq_s evt;
    ffl_irq_s clr;
    logic hit;
    wacc = 1'b0;
    racc = 1'b0;
    wv = '0;
    ev = '0;
    av = '0;
    evt = '0;
    clr = '0;
    hit = 1'b0;
    rstv = '0;
    rstv.empty = 1'b1;
    rstv.aempty = 1'b1;
    rstv.ctrl = FFL_CTRL_RST;
    rstv.thr_hi = THR_HI_RST;
    rstv.thr_lo = THR_LO_RST;
    rstv.awr = 1'b1;
    rstv.wrdy = 1'b1;
    rstv.arr = 1'b1;
    n = s;
    n.wc = {s.wc[FFL_CLK_PIPE-2:0], write_side_clock};
    n.rc = {s.rc[FFL_CLK_PIPE-2:0], read_side_clock};
    n.we = {s.we[0], push_req};
    n.re = {s.re[0], pop_req};
    n.wd = {s.wd[0], push_data};
    // Gate on the registered flags so a pessimistic view never overruns
    wacc = wt & s.we[1] & ~s.full;
    racc = rt & s.re[1] & ~s.empty;
    if (wacc) begin
      n.mem[s.wp[AW-1:0]] = s.wd[1];
      n.wp = PW'(s.wp + ONEV);
    end
    if (racc) begin
      n.rp = PW'(s.rp + ONEV);
    end
    evt.wr_rej = wt & s.we[1] & s.full;
    evt.rd_rej = rt & s.re[1] & s.empty;
    if (wt) begin
      n.rl = {s.rl[N+1:0], s.rp};
      n.ack = wacc;
      n.ovf = evt.wr_rej;
      wv = indep ? n.rl[N+FFL_X_STD_OFS] : n.rp;
      n.full = PW'(n.wp - wv) == FULLV;
      n.afull = PW'(n.wp - wv) >= NEARV;
      if (indep) begin
        n.wcnt = PW'(s.wp - s.rl[N]);
        n.pfull = PW'(s.wp - s.rl[N+FFL_X_STD_OFS]) >= s.thr_hi;
      end else begin
        n.wcnt = PW'(n.wp - n.rp);
        n.pfull = PW'(s.wp - s.rp) >= s.thr_hi;
      end
    end
    if (rt) begin
      n.wl = {s.wl[N+2:0], s.wp};
      n.valid = racc;
      n.udf = evt.rd_rej;
      if (indep) begin
        // Lookahead adds the output stage fill to the crossing
        ev = look ? n.wl[N+FFL_X_LOOK_OFS] : n.wl[N+FFL_X_STD_OFS];
        av = ev;
        n.rcnt = PW'(s.wl[N] - s.rp);
        n.pempty = PW'(s.wl[N+FFL_X_STD_OFS] - s.rp) <= s.thr_lo;
      end else begin
        ev = n.wl[FFL_CC_EMPTY_TAP];
        av = n.wl[FFL_CC_NEAR_TAP];
        n.rcnt = PW'(n.wp - n.rp);
        n.pempty = PW'(s.wp - s.rp) <= s.thr_lo;
      end
      n.empty = ev == n.rp;
      n.aempty = PW'(av - n.rp) <= ONEV;
      if (look) begin
        n.dout = n.mem[n.rp[AW-1:0]];
      end else if (racc) begin
        n.dout = s.mem[s.rp[AW-1:0]];
      end
    end
    n.scnt = PW'(n.wp - n.rp);
    evt.thr_hi = n.pfull & ~s.pfull;
    evt.thr_lo = n.pempty & ~s.pempty;
    // AXI4-Lite write path
    if (awvalid && s.awr) begin
      n.aw_got = 1'b1;
      n.awa = awaddr;
      n.awr = 1'b0;
    end
    if (wvalid && s.wrdy) begin
      n.w_got = 1'b1;
      n.wdat = wdata;
      n.wstb = wstrb[0];
      n.wrdy = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bv) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bv = 1'b1;
      n.br = FFL_OKAY;
      case (s.awa)
        FFL_CTRL: hit = 1'b1;
        FFL_THR_HI: hit = 1'b1;
        FFL_THR_LO: hit = 1'b1;
        FFL_STAT: hit = 1'b1;
        FFL_OCC: hit = 1'b1;
        FFL_IRQ_STAT: hit = 1'b1;
        FFL_IRQ_MASK: hit = 1'b1;
        default: n.br = FFL_SLVERR;
      endcase
      if (hit && s.wstb) begin
        case (s.awa)
          FFL_CTRL: n.ctrl = s.wdat[1:0];
          FFL_THR_HI: n.thr_hi = s.wdat[PW-1:0];
          FFL_THR_LO: n.thr_lo = s.wdat[PW-1:0];
          FFL_IRQ_STAT: clr = s.wdat[FFL_NIRQ-1:0];
          FFL_IRQ_MASK: n.imsk = s.wdat[FFL_NIRQ-1:0];
          default: n.br = FFL_OKAY;
        endcase
      end
    end
    if (s.bv && bready) begin
      n.bv = 1'b0;
      n.awr = 1'b1;
      n.wrdy = 1'b1;
    end
    // New events win over a clear in the same cycle
    n.ist = (s.ist & ~clr) | evt;
    n.irq = |(n.ist & n.imsk);
    // AXI4-Lite read path
    if (arvalid && s.arr) begin
      n.arr = 1'b0;
      n.rv = 1'b1;
      n.rr = FFL_OKAY;
      case (araddr)
        FFL_CTRL: n.rd = 32'(s.ctrl);
        FFL_THR_HI: n.rd = 32'(s.thr_hi);
        FFL_THR_LO: n.rd = 32'(s.thr_lo);
        FFL_STAT: n.rd = 32'({s.udf, s.valid, s.pempty, s.aempty, s.empty,
          s.ovf, s.ack, s.pfull, s.afull, s.full});
        FFL_OCC: n.rd = {8'h00, 8'(s.scnt), 8'(s.rcnt), 8'(s.wcnt)};
        FFL_IRQ_STAT: n.rd = 32'(s.ist);
        FFL_IRQ_MASK: n.rd = 32'(s.imsk);
        default: begin
          n.rd = 32'h0000_0000;
          n.rr = FFL_SLVERR;
        end
      endcase
    end
    if (s.rv && rready) begin
      n.rv = 1'b0;
      n.arr = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    s <= aresetn ? n : rstv;
  end

  assign awready = s.awr;
  assign wready = s.wrdy;
  assign bvalid = s.bv;
  assign bresp = s.br;
  assign arready = s.arr;
  assign rvalid = s.rv;
  assign rdata = s.rd;
  assign rresp = s.rr;
  assign full = s.full;
  assign near_capacity_flag = s.afull;
  assign threshold_high_flag = s.pfull;
  assign write_accept_pulse = s.ack;
  assign write_rejected_flag = s.ovf;
  assign write_side_occupancy = s.wcnt;
  assign pop_data = s.dout;
  assign empty = s.empty;
  assign near_drained_flag = s.aempty;
  assign threshold_low_flag = s.pempty;
  assign read_output_qualifier = s.valid;
  assign read_rejected_flag = s.udf;
  assign read_side_occupancy = s.rcnt;
  assign shared_occupancy_count = s.scnt;
  assign irq = s.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_WR_HS_STABLE: assert property (!wt |=> $stable({s.ack, s.ovf}))
    else $error("write handshake moved without a write tick");
  AST_RD_HS_STABLE: assert property (!rt |=> $stable({s.valid, s.udf}))
    else $error("read handshake moved without a read tick");
  AST_WR_ACK: assert property (wt && s.we[1] && !s.full |=> s.ack && !s.ovf)
    else $error("accepted write not acknowledged");
  AST_WR_OVF: assert property (wt && s.we[1] && s.full |=> s.ovf && !s.ack)
    else $error("write into full fifo not rejected");
  AST_RD_UDF: assert property (rt && s.re[1] && s.empty |=> s.udf && !s.valid
    && $stable(s.rp))
    else $error("read from empty fifo not rejected");
  AST_CC_COUNT: assert property (!indep |-> s.scnt == PW'(s.wp - s.rp)
    && s.full == (s.scnt == FULLV))
    else $error("common mode count or full out of step");
  AST_X_FULL_HOLD: assert property (indep && !wt |=> $stable({s.full,
    s.afull, s.wcnt, s.pfull}))
    else $error("write side flags moved between write ticks");
  AST_X_EMPTY_HOLD: assert property (indep && !rt |=> $stable({s.empty,
    s.aempty, s.rcnt, s.pempty}))
    else $error("read side flags moved between read ticks");
  AST_CC_EMPTY_LAG: assert property (!indep && s.empty && s.wl[0] == s.rp
    && wt && !s.full && s.we[1] |=> s.empty)
    else $error("empty fell on the write edge itself");
  AST_IRQ: assert property (s.irq == |(s.ist & s.imsk))
    else $error("interrupt output disagrees with status and mask");

  COV_FULL: cover property (s.full && wt && s.we[1]);
  COV_EMPTY_UDF: cover property (s.udf && s.empty);
  COV_X_LOOK: cover property (indep && look && $fell(s.empty));
  COV_IRQ: cover property ($rose(s.irq));
endmodule : ffl_fifo

//--- ffl_pkg.sv
// Constants and carrier types for the flag-latency FIFO
package ffl_pkg;
  localparam int unsigned FFL_AW = 8;
  localparam logic [7:0] FFL_CTRL = 8'h00;
  localparam logic [7:0] FFL_THR_HI = 8'h04;
  localparam logic [7:0] FFL_THR_LO = 8'h08;
  localparam logic [7:0] FFL_STAT = 8'h0C;
  localparam logic [7:0] FFL_OCC = 8'h10;
  localparam logic [7:0] FFL_IRQ_STAT = 8'h14;
  localparam logic [7:0] FFL_IRQ_MASK = 8'h18;
  localparam logic [1:0] FFL_OKAY = 2'h0;
  localparam logic [1:0] FFL_SLVERR = 2'h2;
  // Side clock sample pipe: two synchroniser flops plus one edge flop
  localparam int unsigned FFL_CLK_PIPE = 3;
  localparam int unsigned FFL_PIN_SYNC = 2;
  // Read-side taps in common mode, in read ticks after the write less one
  localparam int unsigned FFL_CC_EMPTY_TAP = 1;
  localparam int unsigned FFL_CC_NEAR_TAP = 0;
  // Crossing taps, counted as N plus this offset plus one
  localparam int unsigned FFL_X_STD_OFS = 1;
  localparam int unsigned FFL_X_THR_OFS = 2;
  localparam int unsigned FFL_X_LOOK_OFS = 3;
  localparam int unsigned FFL_NIRQ = 4;
  typedef struct packed {
    logic lookahead_read_mode;
    logic indep;
  } ffl_ctrl_s;
  localparam ffl_ctrl_s FFL_CTRL_RST = 2'h3;
  typedef struct packed {
    logic thr_lo;
    logic thr_hi;
    logic rd_rej;
    logic wr_rej;
  } ffl_irq_s;
endpackage : ffl_pkg

//--- ffl_side_model.sv
// Producer and consumer model driving the gated side clocks
`timescale 1ns/1ps
module ffl_side_model
  import ffl_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input wire logic aclk,
  output logic write_side_clock,
  output logic read_side_clock,
  output logic push_req,
  output logic pop_req,
  output logic [WIDTH-1:0] push_data
);
  initial begin
    write_side_clock = 1'b0;
    read_side_clock = 1'b0;
    push_req = 1'b0;
    pop_req = 1'b0;
    push_data = '0;
  end
  // One side edge; both side clocks stand still between ticks
  task automatic tick(input logic wr_side, input logic psh, input logic pp,
                      input logic [WIDTH-1:0] d);
    @(posedge aclk);
    push_req <= psh;
    pop_req <= pp;
    push_data <= d;
    // Setup covers the sampling flops; edge kept off the aclk edge
    #29;
    if (wr_side)
      write_side_clock = 1'b1;
    else
      read_side_clock = 1'b1;
    #32;
    write_side_clock = 1'b0;
    read_side_clock = 1'b0;
    @(posedge aclk);
    push_req <= 1'b0;
    pop_req <= 1'b0;
    // Released data bus must not keep showing the last word
    push_data <= ~d;
  endtask : tick
endmodule : ffl_side_model

//--- tb_ffl_fifo.sv
// Self-checking bench for the flag-latency FIFO
`timescale 1ns/1ps
module tb_ffl_fifo;
  import ffl_pkg::*;
  localparam int unsigned N = 2;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [7:0] awaddr, araddr, push_data, pop_data;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic write_side_clock, push_req, full, near_capacity_flag;
  logic threshold_high_flag, write_accept_pulse, write_rejected_flag;
  logic read_side_clock, pop_req, empty, near_drained_flag;
  logic threshold_low_flag, read_output_qualifier, read_rejected_flag;
  logic [4:0] write_side_occupancy, read_side_occupancy;
  logic [4:0] shared_occupancy_count;
  int fails, samples_checked, n;
  ffl_fifo #(.N(N)) u_dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .write_side_clock, .push_req, .push_data, .full, .near_capacity_flag,
    .threshold_high_flag, .write_accept_pulse, .write_rejected_flag,
    .write_side_occupancy, .read_side_clock, .pop_req, .pop_data, .empty,
    .near_drained_flag, .threshold_low_flag, .read_output_qualifier,
    .read_rejected_flag, .read_side_occupancy, .shared_occupancy_count,
    .irq);
  ffl_side_model u_side (.aclk, .write_side_clock, .read_side_clock,
    .push_req, .pop_req, .push_data);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  // Handshake outcome is sampled mid-cycle, acted on at the next edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      rsp = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end while (!b);
    check("bresp", rsp, FFL_OKAY);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    logic ar, r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar = arvalid && arready;
      r = rvalid && rready;
      rd = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
    end while (!r);
  endtask : axi_rd
  task automatic t_reset();
    check("empty", empty, 1'b1);
    check("near_drained", near_drained_flag, 1'b1);
    check("full", full, 1'b0);
    axi_rd(FFL_CTRL);
    check("ctrl", rd, 32'h0000_0003);
    axi_rd(8'h40);
    check("unmapped resp", rsp, FFL_SLVERR);
    check("unmapped data", rd, 32'h0000_0000);
    $display("done reset values");
  endtask : t_reset
  task automatic t_std();
    axi_wr(FFL_CTRL, 32'h0000_0001);
    u_side.tick(1'b1, 1'b1, 1'b0, 8'h3C);
    u_side.tick(1'b1, 1'b0, 1'b0, 8'h00);
    check("wcnt s", write_side_occupancy, 5'h01);
    n = 0;
    while (empty !== 1'b0 && n < 12) begin
      u_side.tick(1'b0, 1'b0, 1'b0, 8'h00);
      n++;
    end
    check("empty lat s", n >= N + 2 && n <= N + 3, 1'b1);
    check("rcnt s", read_side_occupancy, 5'h01);
    u_side.tick(1'b0, 1'b0, 1'b1, 8'h00);
    check("valid s", read_output_qualifier, 1'b1);
    check("pop s", pop_data, 8'h3C);
    n = 0;
    while (write_side_occupancy !== 5'h00 && n < 12) begin
      u_side.tick(1'b1, 1'b0, 1'b0, 8'h00);
      n++;
    end
    check("wcnt lat", n >= N + 2 && n <= N + 3, 1'b1);
    axi_wr(FFL_CTRL, 32'h0000_0003);
    $display("done standard crossing");
  endtask : t_std
  task automatic t_cross();
    u_side.tick(1'b1, 1'b1, 1'b0, 8'hA5);
    check("wack", write_accept_pulse, 1'b1);
    check("empty held", empty, 1'b1);
    u_side.tick(1'b1, 1'b0, 1'b0, 8'h00);
    check("wcnt", write_side_occupancy, 5'h01);
    n = 0;
    while (empty !== 1'b0 && n < 12) begin
      u_side.tick(1'b0, 1'b0, 1'b0, 8'h00);
      n++;
    end
    check("empty lat", n >= N + 4 && n <= N + 5, 1'b1);
    check("rcnt", read_side_occupancy, 5'h01);
    check("head", pop_data, 8'hA5);
    u_side.tick(1'b0, 1'b0, 1'b1, 8'h00);
    check("rvalid", read_output_qualifier, 1'b1);
    check("empty pop", empty, 1'b1);
    check("wack kept", write_accept_pulse, 1'b0);
    u_side.tick(1'b0, 1'b0, 1'b1, 8'h00);
    check("rrej", read_rejected_flag, 1'b1);
    check("rq off", read_output_qualifier, 1'b0);
    $display("done independent crossing");
  endtask : t_cross
  task automatic t_common();
    axi_wr(FFL_CTRL, 32'h0000_0002);
    u_side.tick(1'b1, 1'b1, 1'b0, 8'h10);
    check("cnt", shared_occupancy_count, 5'h01);
    check("empty 0", empty, 1'b1);
    u_side.tick(1'b1, 1'b0, 1'b0, 8'h00);
    check("empty 1", empty, 1'b1);
    u_side.tick(1'b1, 1'b0, 1'b0, 8'h00);
    check("empty 2", empty, 1'b0);
    for (int i = 1; i < 16; i++)
      u_side.tick(1'b1, 1'b1, 1'b0, 8'(8'h10 + i));
    check("full", full, 1'b1);
    check("cnt full", shared_occupancy_count, 5'h10);
    check("afull", near_capacity_flag, 1'b1);
    check("tlo c", threshold_low_flag, 1'b0);
    u_side.tick(1'b1, 1'b1, 1'b0, 8'hEE);
    check("wrej", write_rejected_flag, 1'b1);
    check("wack off", write_accept_pulse, 1'b0);
    check("irq masked", irq, 1'b0);
    axi_wr(FFL_IRQ_MASK, 32'h0000_0001);
    check("irq", irq, 1'b1);
    axi_wr(FFL_IRQ_STAT, 32'h0000_0001);
    axi_rd(FFL_IRQ_STAT);
    check("irq stat", rd[0], 1'b0);
    check("irq clr", irq, 1'b0);
    check("head c", pop_data, 8'h10);
    for (int i = 0; i < 3; i++)
      u_side.tick(1'b1, 1'b0, 1'b1, 8'h00);
    check("full rd", full, 1'b0);
    check("cnt rd", shared_occupancy_count, 5'h0D);
    check("afull rd", near_capacity_flag, 1'b0);
    check("thi lat", threshold_high_flag, 1'b1);
    u_side.tick(1'b1, 1'b0, 1'b0, 8'h00);
    check("thi", threshold_high_flag, 1'b0);
    $display("done common mode");
  endtask : t_common
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial begin
    #100000;
    fails++;
    test_done();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awprot, arprot, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    fails = 0;
    samples_checked = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (5) @(posedge aclk);
    t_reset();
    t_std();
    t_cross();
    t_common();
    test_done();
  end
endmodule : tb_ffl_fifo
